/* File: include/eci_pkg.sv */
// ----------------------------------------------------------------------------
// Shared constants for the instruction timing sequencer
// ----------------------------------------------------------------------------
package eci_pkg;

  // ----------------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------------
  localparam int OP_W  = 8;                   // Opcode byte width
  localparam int LEN_W = 2;                   // Instruction length field width
  localparam int CYC_W = 4;                   // Cycle count field width

  // ----------------------------------------------------------------------------
  // Timing counts, in system clock cycles
  // ----------------------------------------------------------------------------
  localparam logic [CYC_W-1:0] CYC_ONE  = 4'h1;  // Shortest instruction
  localparam logic [CYC_W-1:0] CYC_MUL  = 4'h4;  // Multiply accumulator by auxiliary
  localparam logic [CYC_W-1:0] CYC_DIV  = 4'h8;  // Divide accumulator by auxiliary
  localparam logic [CYC_W-1:0] CYC_MAX  = 4'h8;  // Upper bound on any instruction
  localparam logic [CYC_W-1:0] CYC_XMEM = 4'h3;  // External data move / code read

  // ----------------------------------------------------------------------------
  // Decoded timing of one opcode
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic             cond;                   // Conditional branch
    logic [LEN_W-1:0] len;                    // Bytes in program memory
    logic [CYC_W-1:0] cyc;                    // Cycles when not taken
  } eci_dec_t;

  // ----------------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------------
  typedef enum logic {
    ECI_IDLE,                                 // No instruction in flight
    ECI_EXEC                                  // Counting instruction cycles
  } eci_state_t;

endpackage : eci_pkg

/* File: src/eci_timing.sv */
// Functional notes
// - Opcodes, modes, flags match classic instruction set
// - Timing counted only in system clock cycles
// - Most instructions: cycles equal byte count
// - Untaken conditional branch one cycle shorter
// - No instruction exceeds eight cycles
// - One single-cycle instruction per clock peak
// - 109 instructions spread over documented latencies
// - Add/addc/subb: register 1, others 2
// - Logic ops: register 1, others 2, imm-to-direct 3
// - Flash wait stretches instructions variably
// - External data moves take three cycles
// - Code memory reads take three cycles
// - Compare-immediate jump unequal: three or four, @Ri form four or five
`timescale 1ns/1ps
`default_nettype none

module eci_timing (
  // Clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  // Issue side from fetch
  input  wire logic                      issue_i,
  input  wire logic [eci_pkg::OP_W-1:0]  opcode_i,
  input  wire logic                      branch_taken_i,
  // Flash read timing stall from the flash controller
  input  wire logic                      flash_wait_i,
  // Handshake
  output logic                           ready_o,
  output logic                           done_o,
  // Decoded timing of the instruction in flight
  output logic [eci_pkg::LEN_W-1:0]      instr_len_o,
  output logic [eci_pkg::CYC_W-1:0]      cycles_o,
  output logic                           cond_branch_o,
  output logic                           taken_o,
  output logic                           busy_o
);

  // ----------------------------------------------------------------------------
  // Opcode timing table
  // ----------------------------------------------------------------------------
  // Standard opcode map; column default first, then overrides for single opcodes and opcode groups
  function automatic eci_pkg::eci_dec_t decode(input logic [eci_pkg::OP_W-1:0] op);
    eci_pkg::eci_dec_t d;
    // Column defaults by low nibble
    casez (op[3:0])
      4'b1???: d = '{1'b0, 2'h1, eci_pkg::CYC_ONE};       // Rn register forms
      4'b011?: d = '{1'b0, 2'h1, 4'h2};                   // Indirect forms
      4'h5:    d = '{1'b0, 2'h2, 4'h2};                   // Direct forms
      4'h4:    d = '{1'b0, 2'h1, eci_pkg::CYC_ONE};       // Accumulator forms
      4'h3:    d = '{1'b0, 2'h1, eci_pkg::CYC_ONE};       // Bit/carry, rotates
      4'h1:    d = '{1'b0, 2'h2, 4'h3};                   // Absolute jump/call
      default: d = '{1'b0, 2'h2, 4'h2};                   // Columns 0 and 2
    endcase
    // Overrides
    casez (op)
      8'h00:        d = '{1'b0, 2'h1, eci_pkg::CYC_ONE};  // No operation
      8'h10, 8'h20, 8'h30:
                    d = '{1'b1, 2'h3, 4'h3};              // Bit test jumps
      8'h40, 8'h50, 8'h60, 8'h70:
                    d = '{1'b1, 2'h2, 4'h2};              // Carry/zero jumps
      8'h80:        d = '{1'b0, 2'h2, 4'h3};              // Short jump
      8'h90:        d = '{1'b0, 2'h3, 4'h3};              // Load data pointer
      8'hE0, 8'hF0, 8'hE2, 8'hF2, 8'hE3, 8'hF3:
                    d = '{1'b0, 2'h1, eci_pkg::CYC_XMEM}; // External data moves
      8'h02, 8'h12: d = '{1'b0, 2'h3, 4'h4};              // Long jump/call
      8'h22, 8'h32: d = '{1'b0, 2'h1, 4'h5};              // Returns
      8'h43, 8'h53, 8'h63:
                    d = '{1'b0, 2'h3, 4'h3};              // Immediate to direct
      8'h73:        d = '{1'b0, 2'h1, 4'h3};              // Indirect jump
      8'h83, 8'h93: d = '{1'b0, 2'h1, eci_pkg::CYC_XMEM}; // Code memory reads
      8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94:
                    d = '{1'b0, 2'h2, 4'h2};              // Immediate operands
      8'h84:        d = '{1'b0, 2'h1, eci_pkg::CYC_DIV};  // Divide
      8'hA4:        d = '{1'b0, 2'h1, eci_pkg::CYC_MUL};  // Multiply
      8'hB4:        d = '{1'b1, 2'h3, 4'h3};              // Compare immediate to A
      8'h75, 8'h85: d = '{1'b0, 2'h3, 4'h3};              // Three-byte moves
      8'hA5:        d = '{1'b0, 2'h1, eci_pkg::CYC_ONE};  // Reserved opcode
      8'hB5:        d = '{1'b1, 2'h3, 4'h4};              // Compare direct to A
      8'hD5:        d = '{1'b1, 2'h3, 4'h3};              // Decrement direct, jump
      8'b0111_011?, 8'b1000_011?, 8'b1010_011?:
                    d = '{1'b0, 2'h2, 4'h2};              // Indirect with operand byte
      8'b1011_011?: d = '{1'b1, 2'h3, 4'h4};              // Compare indirect
      8'b0111_1???, 8'b1000_1???, 8'b1010_1???:
                    d = '{1'b0, 2'h2, 4'h2};              // Rn with operand byte
      8'b1011_1???: d = '{1'b1, 2'h3, 4'h3};              // Compare Rn immediate
      8'b1101_1???: d = '{1'b1, 2'h2, 4'h2};              // Decrement Rn, jump
      default:      d = d;                                // Keep column default
    endcase
    return d;
  endfunction : decode

  // ----------------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------------
  eci_pkg::eci_state_t          state;                 // Current state
  eci_pkg::eci_state_t          next_state;            // Next state
  logic [eci_pkg::CYC_W-1:0]    remain;                // Cycles left in flight
  logic [eci_pkg::CYC_W-1:0]    next_remain;           // Next cycles left
  logic [eci_pkg::LEN_W-1:0]    next_instr_len;        // Next length output
  logic [eci_pkg::CYC_W-1:0]    next_cycles;           // Next cycle total
  logic                         next_cond;             // Next branch flag
  logic                         next_taken;            // Next taken flag
  eci_pkg::eci_dec_t            dec;                   // Decode of opcode_i
  logic                         accept;                // Issue taken this edge
  logic [eci_pkg::CYC_W-1:0]    total;                 // Cycles incl. taken branch

  // Decode and handshake terms
  always_comb begin
    dec     = decode(opcode_i);
    total   = dec.cyc + {3'h0, dec.cond & branch_taken_i};
    done_o  = (state == eci_pkg::ECI_EXEC) && (remain == eci_pkg::CYC_ONE)
              && !flash_wait_i;
    ready_o = (state == eci_pkg::ECI_IDLE) || done_o;
    accept  = issue_i && ready_o;
    busy_o  = (state == eci_pkg::ECI_EXEC);
  end

  // Next-state logic: count whole clock cycles, hold while flash waits
  always_comb begin
    next_state     = state;
    next_remain    = remain;
    next_instr_len = instr_len_o;
    next_cycles    = cycles_o;
    next_cond      = cond_branch_o;
    next_taken     = taken_o;
    case (state)
      eci_pkg::ECI_IDLE: begin
        // Waiting for fetch to offer an opcode
      end
      eci_pkg::ECI_EXEC: begin
        if (!flash_wait_i) begin
          next_remain = remain - eci_pkg::CYC_ONE;
        end
        if (done_o) begin
          next_state = eci_pkg::ECI_IDLE;
        end
      end
      default: begin
        next_state = eci_pkg::ECI_IDLE;
      end
    endcase
    // A new instruction may start in the last cycle of the previous one
    if (accept) begin
      next_state     = eci_pkg::ECI_EXEC;
      next_remain    = total;
      next_instr_len = dec.len;
      next_cycles    = total;
      next_cond      = dec.cond;
      next_taken     = dec.cond & branch_taken_i;
    end
  end

  // Registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state         <= eci_pkg::ECI_IDLE;
      remain        <= 4'h0;
      instr_len_o   <= 2'h0;
      cycles_o      <= 4'h0;
      cond_branch_o <= 1'b0;
      taken_o       <= 1'b0;
    end else begin
      state         <= next_state;
      remain        <= next_remain;
      instr_len_o   <= next_instr_len;
      cycles_o      <= next_cycles;
      cond_branch_o <= next_cond;
      taken_o       <= next_taken;
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Helper: unstalled cycles spent on the instruction in flight
  logic [eci_pkg::CYC_W-1:0] act_cnt;       // Unstalled cycles so far
  logic [eci_pkg::CYC_W-1:0] next_act_cnt;  // Next unstalled count

  // Restart on each issue, count only cycles that are not stalled
  always_comb begin
    next_act_cnt = act_cnt;
    if (accept) begin
      next_act_cnt = 4'h0;
    end else if (busy_o && !flash_wait_i) begin
      next_act_cnt = act_cnt + 4'h1;
    end
  end

  // Helper register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      act_cnt <= 4'h0;
    end else begin
      act_cnt <= next_act_cnt;
    end
  end

  sequence s_issue_op(logic [7:0] op);
    accept && (opcode_i == op);
  endsequence

  chk_count_matches: assert property (done_o |-> act_cnt + 4'h1 == cycles_o)
    else $error("instruction ended after wrong cycle count");
  chk_max_bound: assert property (busy_o |-> cycles_o <= eci_pkg::CYC_MAX)
    else $error("instruction exceeds eight cycles");
  chk_branch_extra: assert property (accept && dec.cond
    |=> cycles_o == $past(dec.cyc) + {3'h0, $past(branch_taken_i)})
    else $error("branch latency not one more when taken");
  chk_mul_four: assert property (s_issue_op(8'hA4) |=> cycles_o == 4'h4)
    else $error("multiply latency wrong");
  chk_div_eight: assert property (s_issue_op(8'h84) ##1 !flash_wait_i [*8]
    |-> done_o)
    else $error("divide did not finish in eight cycles");
  chk_xmem_three: assert property (accept && (opcode_i[7:5] == 3'h7)
    && (opcode_i[3:0] inside {4'h0, 4'h2, 4'h3}) |=> cycles_o == 4'h3)
    else $error("external data move latency wrong");
  chk_code_read: assert property (accept && (opcode_i inside {8'h83, 8'h93})
    |=> cycles_o == 4'h3 && instr_len_o == 2'h1)
    else $error("code memory read latency wrong");
  chk_compare_jump_unequal_imm: assert property (s_issue_op(8'hB4)
    |=> cycles_o == (taken_o ? 4'h4 : 4'h3))
    else $error("compare immediate jump latency wrong");
  chk_add_reg: assert property (accept && (opcode_i[7:4] inside {4'h2, 4'h3, 4'h9})
    && opcode_i[3] |=> cycles_o == 4'h1)
    else $error("register add latency wrong");
  chk_logic_imm: assert property (accept && (opcode_i inside {8'h43, 8'h53, 8'h63})
    |=> cycles_o == 4'h3 && instr_len_o == 2'h3)
    else $error("immediate to direct logic latency wrong");
  chk_one_per_clock: assert property (accept && total == 4'h1 ##1 !flash_wait_i
    |-> done_o && ready_o)
    else $error("single cycle instruction did not retire");
  chk_wait_hold: assert property (busy_o && flash_wait_i && !accept
    |-> !done_o ##1 $stable(remain))
    else $error("flash wait did not hold the instruction");

endmodule : eci_timing

`default_nettype wire

/* File: testbench/eci_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Flash controller stand-in: stretches each instruction by a set wait count
// ----------------------------------------------------------------------------
module eci_flash_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Sequencer status and wait setting
  input  wire logic       busy_i,
  input  wire logic       done_i,
  input  wire logic [3:0] wait_n_i,
  // Stall to the sequencer
  output logic            flash_wait_o
);
  logic [3:0] wait_left;  // Stall cycles still owed to this instruction

  // Stall in the first cycles of an instruction while waits are owed
  assign flash_wait_o = busy_i && (wait_left != 4'h0);

  // Reload between instructions, count down while stalling
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_left <= 4'h0;
    end else if (!busy_i || done_i) begin
      wait_left <= wait_n_i;
    end else if (wait_left != 4'h0) begin
      wait_left <= wait_left - 4'h1;
    end
  end
endmodule : eci_flash_model

`default_nettype wire

/* File: testbench/eci_timing_test.sv */
`timescale 1ns/1ps
`default_nettype none

module eci_timing_test;
  // ----------------------------------------------------------------------------
  // Signals and opcode table
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] op;   // Opcode byte
    logic [1:0] len;  // Expected byte length
    logic [3:0] cyc;  // Expected cycles when not taken
    logic       cond; // Conditional branch
  } eci_case_t;
  localparam int NCASE = 43;  // Table entries
  eci_case_t cases [NCASE] = '{
    '{8'h28, 2'h1, 4'h1, 1'h0}, '{8'h38, 2'h1, 4'h1, 1'h0}, '{8'h98, 2'h1, 4'h1, 1'h0},
    '{8'h25, 2'h2, 4'h2, 1'h0}, '{8'h24, 2'h2, 4'h2, 1'h0}, '{8'h26, 2'h1, 4'h2, 1'h0},
    '{8'h96, 2'h1, 4'h2, 1'h0}, '{8'h58, 2'h1, 4'h1, 1'h0}, '{8'h48, 2'h1, 4'h1, 1'h0},
    '{8'h68, 2'h1, 4'h1, 1'h0}, '{8'h66, 2'h1, 4'h2, 1'h0}, '{8'h52, 2'h2, 4'h2, 1'h0},
    '{8'h53, 2'h3, 4'h3, 1'h0}, '{8'h43, 2'h3, 4'h3, 1'h0}, '{8'h63, 2'h3, 4'h3, 1'h0},
    '{8'hA4, 2'h1, 4'h4, 1'h0}, '{8'h84, 2'h1, 4'h8, 1'h0}, '{8'hE0, 2'h1, 4'h3, 1'h0},
    '{8'hF0, 2'h1, 4'h3, 1'h0}, '{8'hE2, 2'h1, 4'h3, 1'h0}, '{8'hF2, 2'h1, 4'h3, 1'h0},
    '{8'h93, 2'h1, 4'h3, 1'h0}, '{8'h83, 2'h1, 4'h3, 1'h0}, '{8'h40, 2'h2, 4'h2, 1'h1},
    '{8'h20, 2'h3, 4'h3, 1'h1}, '{8'hB4, 2'h3, 4'h3, 1'h1}, '{8'hB5, 2'h3, 4'h4, 1'h1},
    '{8'h22, 2'h1, 4'h5, 1'h0}, '{8'h02, 2'h3, 4'h4, 1'h0}, '{8'h11, 2'h2, 4'h3, 1'h0},
    '{8'h73, 2'h1, 4'h3, 1'h0}, '{8'h80, 2'h2, 4'h3, 1'h0}, '{8'h90, 2'h3, 4'h3, 1'h0},
    '{8'h75, 2'h3, 4'h3, 1'h0}, '{8'h76, 2'h2, 4'h2, 1'h0}, '{8'hE6, 2'h1, 4'h2, 1'h0},
    '{8'hA8, 2'h2, 4'h2, 1'h0}, '{8'hB6, 2'h3, 4'h4, 1'h1}, '{8'hB8, 2'h3, 4'h3, 1'h1},
    '{8'hD8, 2'h2, 4'h2, 1'h1}, '{8'h70, 2'h2, 4'h2, 1'h1}, '{8'hF3, 2'h1, 4'h3, 1'h0},
    '{8'h04, 2'h1, 4'h1, 1'h0}};
  logic       clk_i = 1'h0;           // System clock
  logic       sys_rst_i = 1'h1;       // Reset
  logic       issue_i = 1'h0;         // Issue strobe
  logic [7:0] opcode_i = 8'h00;       // Offered opcode
  logic       branch_taken_i = 1'h0;  // Branch outcome
  logic [3:0] wait_n = 4'h0;          // Stall cycles per instruction
  logic       flash_wait_i;           // Stall from flash model
  logic       ready_o, done_o, cond_branch_o, taken_o, busy_o;  // Status outputs
  logic [1:0] instr_len_o;            // Reported length
  logic [3:0] cycles_o;               // Reported cycles
  int         err_count = 0;          // Mismatches
  int         n_compared = 0;         // Comparisons
  int         cyc_cnt = 0;            // Watchdog count

  eci_timing dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .issue_i(issue_i),
    .opcode_i(opcode_i), .branch_taken_i(branch_taken_i), .flash_wait_i(flash_wait_i),
    .ready_o(ready_o), .done_o(done_o), .instr_len_o(instr_len_o), .cycles_o(cycles_o),
    .cond_branch_o(cond_branch_o), .taken_o(taken_o), .busy_o(busy_o));
  eci_flash_model flash_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .busy_i(busy_o),
    .done_i(done_o), .wait_n_i(wait_n), .flash_wait_o(flash_wait_i));

  // ----------------------------------------------------------------------------
  // Clock, watchdog, helpers
  // ----------------------------------------------------------------------------
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Cut a hang short well past the expected run length
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test
  // Issue one opcode, judge its report and count cycles to retirement
  task automatic run_op(input eci_case_t c, input logic tk, input logic [3:0] waits);
    int n;
    @(posedge clk_i);
    issue_i <= 1'h1;
    opcode_i <= c.op;
    branch_taken_i <= tk;
    wait_n <= waits;
    do @(negedge clk_i); while (ready_o !== 1'h1);
    @(posedge clk_i);
    issue_i <= 1'h0;
    @(negedge clk_i);
    check(8'(instr_len_o), 8'(c.len), "length");
    check(8'(cond_branch_o), 8'(c.cond), "cond");
    check(8'(taken_o), 8'(c.cond & tk), "taken");
    check(8'(cycles_o), 8'(c.cyc + (c.cond & tk)), "cycles");
    n = 1;
    while (done_o !== 1'h1 && n < 20) begin
      @(negedge clk_i);
      n++;
    end
    check(8'(n), 8'(c.cyc + (c.cond & tk) + waits), "retire");
  endtask : run_op

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic test_table();
    for (int i = 0; i < NCASE; i++) begin
      run_op(cases[i], 1'h0, 4'h0);
      if (cases[i].cond) run_op(cases[i], 1'h1, 4'h0);
    end
    $display("test_table done");
  endtask : test_table
  // Single-cycle opcodes retire one per clock
  task automatic test_back_to_back();
    @(posedge clk_i);
    issue_i <= 1'h1;
    opcode_i <= 8'h28;
    @(posedge clk_i);
    repeat (4) begin
      @(negedge clk_i);
      check(8'(done_o), 8'h01, "streaming");
      @(posedge clk_i);
    end
    issue_i <= 1'h0;
    @(negedge clk_i);
    check(8'(done_o), 8'h01, "last");
    @(negedge clk_i);
    check(8'(busy_o), 8'h00, "idle");
    $display("test_back_to_back done");
  endtask : test_back_to_back
  // An issue during a long instruction waits until its last cycle
  task automatic test_refused();
    @(posedge clk_i);
    issue_i <= 1'h1;
    opcode_i <= 8'h84;
    @(posedge clk_i);
    opcode_i <= 8'h28;
    repeat (7) begin
      @(negedge clk_i);
      check(8'(cycles_o), 8'h08, "held");
      check(8'(ready_o), 8'h00, "refused");
    end
    @(negedge clk_i);
    check(8'(done_o), 8'h01, "divide end");
    @(posedge clk_i);
    issue_i <= 1'h0;
    @(negedge clk_i);
    check(8'(cycles_o), 8'h01, "next");
    check(8'(done_o), 8'h01, "next retire");
    $display("test_refused done");
  endtask : test_refused
  // Flash stalls stretch retirement by the stall count
  task automatic test_flash_wait();
    run_op(cases[16], 1'h0, 4'h3);
    run_op(cases[25], 1'h1, 4'h2);
    run_op(cases[0], 1'h0, 4'h1);
    $display("test_flash_wait done");
  endtask : test_flash_wait
  // Reset in the middle of a divide clears the sequencer, then work resumes
  task automatic test_mid_reset();
    @(posedge clk_i);
    issue_i <= 1'h1;
    opcode_i <= 8'h84;
    @(posedge clk_i);
    issue_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'h1;
    @(negedge clk_i);
    check({ready_o, done_o, busy_o, cond_branch_o, cycles_o}, 8'h80, "mid reset");
    @(posedge clk_i);
    sys_rst_i <= 1'h0;
    run_op(cases[0], 1'h0, 4'h0);
    $display("test_mid_reset done");
  endtask : test_mid_reset

  // ----------------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    check({ready_o, done_o, busy_o, cond_branch_o, cycles_o}, 8'h80, "reset");
    @(posedge clk_i);
    sys_rst_i <= 1'h0;
    test_table();
    test_back_to_back();
    test_refused();
    test_flash_wait();
    test_mid_reset();
    end_of_test();
  end
endmodule : eci_timing_test

`default_nettype wire
